/* rtl/rpp_pkg.sv */
// Constants shared by the condition-input block of the reduced power stage
// PWM: register offsets, control field layout, mode codes and phase codes.
// Assumes a 32-bit APB register bus and a single PWM clock domain.
package rpp_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_A_OFS = 12'h000;
    localparam logic [11:0] CTRL_B_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;

    // ****************************************************************
    // Input control register fields
    // ****************************************************************
    localparam int CTRL_W = 9;
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int POL_BIT = 4;
    localparam int EDGE_BIT = 5;
    localparam int FILT_BIT = 6;
    localparam int SRC_BIT = 7;
    localparam int ASYNC_BIT = 8;

    // ****************************************************************
    // Status register fields (event bits are write-one-to-clear)
    // ****************************************************************
    localparam int ST_ACTIVE_LSB = 0;
    localparam int ST_HOLD_LSB = 2;
    localparam int ST_EVENT_LSB = 4;
    localparam int ST_BADMODE_LSB = 6;
    localparam int ST_W = 8;

    // ****************************************************************
    // Input mode codes and waveform phase codes
    // ****************************************************************
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_JUMP_WAIT = 4'h1;
    localparam logic [3:0] MODE_LAST_LOW = 4'h9;
    localparam logic [3:0] MODE_FIXED_KILL = 4'he;
    localparam logic [1:0] PH_DEAD_A = 2'h0;
    localparam logic [1:0] PH_ON_A = 2'h1;
    localparam logic [1:0] PH_DEAD_B = 2'h2;
    localparam logic [1:0] PH_ON_B = 2'h3;

    // ****************************************************************
    // Filter length and per-channel hold state
    // ****************************************************************
    localparam int FILTER_LEN = 4;

    typedef enum logic {
        RPP_IDLE,
        RPP_HOLD
    } rpp_hold_e;

endpackage

/* rtl/rpp_input_chan.sv */
// One condition-input channel: source select, two-stage synchroniser,
// optional four-cycle noise filter, polarity and edge/level qualification.
// Assumes pins and comparator are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module rpp_input_chan
    import rpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic cmp_in,
    input wire logic src_cmp,
    input wire logic polarity,
    input wire logic edge_mode,
    input wire logic filter_en,
    output logic active,
    output logic trig
);

    typedef struct packed {
        logic [1:0] pin_sync;
        logic [1:0] cmp_sync;
        logic [FILTER_LEN-2:0] hist;
        logic level;
        logic prev;
    } rpp_chan_s;

    rpp_chan_s st_q;
    rpp_chan_s st_d;
    logic sample;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // Both sources are synchronised so a source switch never glitches
        st_d.pin_sync = {st_q.pin_sync[0], pin_in};
        st_d.cmp_sync = {st_q.cmp_sync[0], cmp_in};
        sample = src_cmp ? st_q.cmp_sync[1] : st_q.pin_sync[1];
        st_d.hist = {st_q.hist[FILTER_LEN-3:0], sample};
        // Filter adds latency; software may bypass it for slow clocks
        if (!filter_en) begin
            st_d.level = sample;
        end else if (&{st_q.hist, sample} || ~|{st_q.hist, sample}) begin
            st_d.level = sample;
        end
        st_d.prev = st_q.level;
    end

    // Registered state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Active level and event, taken from flip-flops only
    assign active = st_q.level ~^ polarity;
    assign trig = edge_mode ? (active & ~(st_q.prev ~^ polarity)) : active;

endmodule
`default_nettype wire

/* rtl/rpp_input_ctl.sv */
// Condition-input block of the reduced power stage PWM with APB registers.
// Assumes the waveform generator on pclk supplies phase, ramp mode and the
// raw output levels, and acts on the jump and counter-clear pulses.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rpp_input_ctl
    import rpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_condition_pin_a,
    input wire logic external_condition_pin_b,
    input wire logic comparator_a,
    input wire logic comparator_b,
    input wire logic one_ramp_mode,
    input wire logic [1:0] wave_phase,
    input wire logic gen_out_a,
    input wire logic gen_out_b,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic sub_cycle_a_end,
    output logic sub_cycle_b_end,
    output logic counter_clear
);

    typedef struct packed {
        logic [1:0][CTRL_W-1:0] ctrl;
        rpp_hold_e [1:0] hold;
        logic [1:0] kill;
        logic [1:0] evt;
        logic [1:0] jump;
        logic clear;
        logic [31:0] rdata;
        logic err;
    } rpp_top_s;

    rpp_top_s st_q;
    rpp_top_s st_d;
    logic [1:0] ch_active;
    logic [1:0] ch_trig;
    logic [1:0] raw_active;
    logic async_kill;
    logic setup;
    logic access;
    logic [ST_W-1:0] status;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Mode field of a control word
    function automatic logic [MODE_W-1:0] mode_of(
        input logic [CTRL_W-1:0] c
    );
        mode_of = c[MODE_LSB +: MODE_W];
    endfunction

    // Reserved mode codes fall outside 0..9 and 14
    function automatic logic mode_bad(input logic [MODE_W-1:0] m);
        mode_bad = (m > MODE_LAST_LOW) && (m != MODE_FIXED_KILL);
    endfunction

    // Whether channel ch may act in the present waveform phase
    function automatic logic honoured(
        input logic ch,
        input logic one_ramp,
        input logic [1:0] ph
    );
        if (one_ramp) begin
            honoured = 1'b1;
        end else if (!ch) begin
            honoured = (ph == PH_DEAD_A) || (ph == PH_ON_A);
        end else begin
            honoured = (ph == PH_DEAD_B) || (ph == PH_ON_B);
        end
    endfunction

    // ****************************************************************
    // Input channels
    // ****************************************************************

    // Channel A serves output half A
    rpp_input_chan u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(external_condition_pin_a),
        .cmp_in(comparator_a),
        .src_cmp(st_q.ctrl[0][SRC_BIT]),
        .polarity(st_q.ctrl[0][POL_BIT]),
        .edge_mode(st_q.ctrl[0][EDGE_BIT]),
        .filter_en(st_q.ctrl[0][FILT_BIT]),
        .active(ch_active[0]),
        .trig(ch_trig[0])
    );

    // Channel B serves output half B
    rpp_input_chan u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(external_condition_pin_b),
        .cmp_in(comparator_b),
        .src_cmp(st_q.ctrl[1][SRC_BIT]),
        .polarity(st_q.ctrl[1][POL_BIT]),
        .edge_mode(st_q.ctrl[1][EDGE_BIT]),
        .filter_en(st_q.ctrl[1][FILT_BIT]),
        .active(ch_active[1]),
        .trig(ch_trig[1])
    );

    // ****************************************************************
    // Asynchronous output kill
    // ****************************************************************

    // Raw selected pin or comparator levels, no flip-flop: works even with a stopped clock.
    // The clocked channels keep running beside this path.
    assign raw_active[0] = (st_q.ctrl[0][SRC_BIT] ? comparator_a
        : external_condition_pin_a) ~^ st_q.ctrl[0][POL_BIT];
    assign raw_active[1] = (st_q.ctrl[1][SRC_BIT] ? comparator_b
        : external_condition_pin_b) ~^ st_q.ctrl[1][POL_BIT];
    assign async_kill = (st_q.ctrl[0][ASYNC_BIT] & raw_active[0])
        | (st_q.ctrl[1][ASYNC_BIT] & raw_active[1]);

    // Output gating: clocked kill per half, async kill on both halves
    assign pwm_out_a = gen_out_a & ~st_q.kill[0] & ~async_kill;
    assign pwm_out_b = gen_out_b & ~st_q.kill[1] & ~async_kill;

    // ****************************************************************
    // APB decode and status
    // ****************************************************************
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & st_q.err;
    assign prdata = st_q.rdata;

    // Status view of live channel state
    always_comb begin
        status = '0;
        status[ST_ACTIVE_LSB +: 2] = ch_active;
        status[ST_HOLD_LSB] = (st_q.hold[0] == RPP_HOLD);
        status[ST_HOLD_LSB + 1] = (st_q.hold[1] == RPP_HOLD);
        status[ST_EVENT_LSB +: 2] = st_q.evt;
        status[ST_BADMODE_LSB] = mode_bad(mode_of(st_q.ctrl[0]));
        status[ST_BADMODE_LSB + 1] = mode_bad(mode_of(st_q.ctrl[1]));
    end

    // ****************************************************************
    // Next state: registers, mode 1 sequencing, jump pulses
    // ****************************************************************
    always_comb begin
        logic [1:0] ev_set;
        logic [1:0] ev_clr;
        logic acts;
        ev_set = '0;
        ev_clr = '0;
        acts = 1'b0;
        st_d = st_q;
        st_d.jump = '0;
        st_d.clear = 1'b0;

        // Read data and error are captured in the setup cycle
        if (setup) begin
            st_d.err = 1'b0;
            st_d.rdata = '0;
            unique case (paddr)
                CTRL_A_OFS: st_d.rdata[CTRL_W-1:0] = st_q.ctrl[0];
                CTRL_B_OFS: st_d.rdata[CTRL_W-1:0] = st_q.ctrl[1];
                STATUS_OFS: st_d.rdata[ST_W-1:0] = status;
                default: st_d.err = 1'b1;
            endcase
        end

        // Writes take effect at the access edge
        if (access && pwrite) begin
            unique case (paddr)
                CTRL_A_OFS: st_d.ctrl[0] = pwdata[CTRL_W-1:0];
                CTRL_B_OFS: st_d.ctrl[1] = pwdata[CTRL_W-1:0];
                STATUS_OFS: ev_clr = pwdata[ST_EVENT_LSB +: 2];
                default: ;
            endcase
        end

        // Each channel sequences its own half independently
        for (int i = 0; i < 2; i++) begin
            acts = ch_trig[i] && honoured(i[0], one_ramp_mode, wave_phase);
            if (acts && (mode_of(st_q.ctrl[i]) != MODE_NONE)
                && !mode_bad(mode_of(st_q.ctrl[i]))) begin
                ev_set[i] = 1'b1;
            end
            unique case (st_q.hold[i])
                RPP_IDLE: begin
                    if (acts && mode_of(st_q.ctrl[i]) == MODE_JUMP_WAIT) begin
                        // Drop this half's output and wait
                        st_d.kill[i] = 1'b1;
                        st_d.hold[i] = RPP_HOLD;
                    end
                end
                RPP_HOLD: begin
                    if (!ch_active[i]) begin
                        // Input released: jump to the opposite half, or clear the counter in one ramp
                        st_d.kill[i] = 1'b0;
                        st_d.hold[i] = RPP_IDLE;
                        if (one_ramp_mode) begin
                            st_d.clear = 1'b1;
                        end else begin
                            st_d.jump[i] = 1'b1;
                        end
                    end
                end
            endcase
        end

        // A new event outweighs a clear in the same cycle
        st_d.evt = (st_q.evt & ~ev_clr) | ev_set;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.ctrl <= {CTRL_RST, CTRL_RST};
            st_q.hold <= '{RPP_IDLE, RPP_IDLE};
            st_q.kill <= 2'h0;
            st_q.evt <= 2'h0;
            st_q.jump <= 2'h0;
            st_q.clear <= 1'b0;
            st_q.rdata <= 32'h0000_0000;
            st_q.err <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Pulses to the waveform generator, one clock each
    assign sub_cycle_a_end = st_q.jump[0];
    assign sub_cycle_b_end = st_q.jump[1];
    assign counter_clear = st_q.clear;

endmodule
`default_nettype wire

/* tb/rpp_input_ctl_props.sv */
// Port checker for the condition-input block, bound to its top module.
// Assumes a single pclk domain with asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module rpp_input_ctl_props
    import rpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_condition_pin_a,
    input wire logic external_condition_pin_b,
    input wire logic comparator_a,
    input wire logic comparator_b,
    input wire logic one_ramp_mode,
    input wire logic [1:0] wave_phase,
    input wire logic gen_out_a,
    input wire logic gen_out_b,
    input wire logic pwm_out_a,
    input wire logic pwm_out_b,
    input wire logic sub_cycle_a_end,
    input wire logic sub_cycle_b_end,
    input wire logic counter_clear
);
    // ****************************************************************
    // Relations between the ports
    // ****************************************************************
    // Everything runs on pclk, so one default clock and reset suffice
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_HIGH: assert property (psel && penable |-> pready)
        else $error("pready low in access cycle");
    AST_UNMAPPED_ERR: assert property
        (psel && penable && paddr > STATUS_OFS |-> pslverr)
        else $error("no error on unmapped address");
    AST_OUT_A_GATED: assert property (pwm_out_a |-> gen_out_a)
        else $error("output a high while generator low");
    AST_OUT_B_GATED: assert property (!gen_out_b |-> !pwm_out_b)
        else $error("output b high while generator low");
    AST_A_END_PULSE: assert property
        (sub_cycle_a_end |=> !sub_cycle_a_end)
        else $error("sub cycle a end longer than one cycle");
    AST_B_END_PULSE: assert property
        ($rose(sub_cycle_b_end) |=> $fell(sub_cycle_b_end))
        else $error("sub cycle b end longer than one cycle");
    AST_CLEAR_ONE_RAMP: assert property
        (counter_clear |-> $past(one_ramp_mode))
        else $error("counter clear outside one ramp");
    AST_END_MULTI: assert property
        ((sub_cycle_a_end || sub_cycle_b_end) |-> !$past(one_ramp_mode))
        else $error("sub cycle end in one ramp");
    AST_CLEAR_SHORT: assert property
        (counter_clear |=> !counter_clear [*2])
        else $error("counter clear repeated too soon");
    // Main scenarios reached
    cover property (sub_cycle_a_end);
    cover property (sub_cycle_b_end);
    cover property (counter_clear);
    cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

/* tb/rpp_cond_src.sv */
// Far-side model: condition pins and comparator outputs.
// Assumes the bench sets levels just after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module rpp_cond_src (
    input wire logic lvl_a,
    input wire logic lvl_b,
    input wire logic cmp_a_lvl,
    input wire logic cmp_b_lvl,
    input wire logic glitch_a,
    output logic pin_a,
    output logic pin_b,
    output logic cmp_a,
    output logic cmp_b
);
    // ****************************************************************
    // Source levels, pin a may carry a short noise spike
    // ****************************************************************
    // Spike is a single clock long so only an unfiltered path can see it
    assign pin_a = lvl_a ^ glitch_a;
    assign pin_b = lvl_b;
    assign cmp_a = cmp_a_lvl;
    assign cmp_b = cmp_b_lvl;
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the condition-input block.
// Assumes the package constants and a 50 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rpp_pkg::*;
;
    // ****************************************************************
    // Signals, model state and shared tasks
    // ****************************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    logic one_ramp, gen_a, gen_b, out_a, out_b, end_a, end_b, clr;
    logic lvl_a, lvl_b, cmpv_a, cmpv_b, glitch_a, pin_a, pin_b, cmp_a, cmp_b;
    logic [1:0] phase;
    logic [31:0] regs [3];
    int num_errors, checks_done;
    rpp_input_ctl u_rpp_input_ctl (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_condition_pin_a(pin_a), .external_condition_pin_b(pin_b),
        .comparator_a(cmp_a), .comparator_b(cmp_b), .one_ramp_mode(one_ramp),
        .wave_phase(phase), .gen_out_a(gen_a), .gen_out_b(gen_b),
        .pwm_out_a(out_a), .pwm_out_b(out_b), .sub_cycle_a_end(end_a),
        .sub_cycle_b_end(end_b), .counter_clear(clr));
    rpp_cond_src u_rpp_cond_src (.lvl_a(lvl_a), .lvl_b(lvl_b),
        .cmp_a_lvl(cmpv_a), .cmp_b_lvl(cmpv_b), .glitch_a(glitch_a),
        .pin_a(pin_a), .pin_b(pin_b), .cmp_a(cmp_a), .cmp_b(cmp_b));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Model: only mode 1 kills, and only inside the own half unless one ramp
    function automatic logic mk(input logic [8:0] c, input logic ch);
        return c[3:0] == MODE_JUMP_WAIT && (one_ramp || phase[1] == ch);
    endfunction
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high, for at most 16 cycles
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        if (n == 16) begin
            num_errors++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a < STATUS_OFS) regs[a[3:2]] = d & 32'h1ff;
    endtask
    task automatic rdchk(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        chk("ctrl", regs[a[3:2]], q);
    endtask
    task automatic drive(input logic ch, input logic v);
        @(posedge pclk);
        if (ch) cmpv_b <= v;
        else lvl_a <= v;
    endtask
    // Assert the input, look for the kill, release it, look for the end
    task automatic kill_test(input logic ch, input logic act, input logic x);
        logic seen;
        drive(ch, act);
        seen = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            #1;
            if ((ch ? out_b : out_a) === 1'b0) seen = 1'b1;
        end
        chk("kill", {31'h0, x}, {31'h0, seen});
        drive(ch, ~act);
        seen = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            #1;
            if ((one_ramp ? clr : (ch ? end_b : end_a)) === 1'b1) seen = 1'b1;
        end
        chk("release", {31'h0, x}, {31'h0, seen});
        chk("output back", 32'h1, {31'h0, ch ? out_b : out_a});
        // Hand back at a rising edge so callers drive on the edge
        @(posedge pclk);
    endtask
    // ****************************************************************
    // Clock and main sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, one_ramp, glitch_a} = 6'h00;
        {lvl_a, lvl_b, cmpv_a, gen_a, gen_b, cmpv_b} = 6'h0f;
        {paddr, pwdata, phase} = {12'h000, 32'h0, PH_ON_A};
        regs = '{32'h0, 32'h0, 32'h0};
        {num_errors, checks_done} = {32'sd0, 32'sd0};
        seed = 32'hd80d6181;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 2; i++) rdchk(12'(4 * i));
        apb(1'b1, 12'h00c, 32'hffffffff);
        chk("slverr", 32'h1, {31'h0, e});
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            apb(1'b1, 12'(4 * (i % 2)), seed);
            rdchk(12'(4 * (i % 2)));
        end
        // Polarity set: a hold left by a random mode 1 word is released
        apb(1'b1, CTRL_A_OFS, 32'h10);
        apb(1'b1, CTRL_B_OFS, 32'h0);
        repeat (12) @(posedge pclk);
        // Every mode code, level sensing, rising active, own half
        for (int m = 0; m < 16; m++) begin
            apb(1'b1, CTRL_A_OFS, 32'h10 | m);
            kill_test(1'b0, 1'b1, mk(regs[0][8:0], 1'b0));
        end
        apb(1'b1, CTRL_A_OFS, 32'h0);
        apb(1'b1, CTRL_B_OFS, 32'h0a1);
        phase <= PH_ON_B;
        kill_test(1'b1, 1'b0, 1'b1);
        apb(1'b1, CTRL_B_OFS, 32'h0);
        apb(1'b1, CTRL_A_OFS, 32'h011);
        kill_test(1'b0, 1'b1, mk(regs[0][8:0], 1'b0));
        one_ramp <= 1'b1;
        kill_test(1'b0, 1'b1, 1'b1);
        one_ramp <= 1'b0;
        phase <= PH_DEAD_A;
        apb(1'b1, CTRL_A_OFS, 32'h051);
        @(posedge pclk);
        glitch_a <= 1'b1;
        @(posedge pclk);
        glitch_a <= 1'b0;
        repeat (12) @(posedge pclk);
        #1;
        chk("spike", 32'h1, {31'h0, out_a});
        kill_test(1'b0, 1'b1, 1'b1);
        apb(1'b1, CTRL_A_OFS, 32'h110);
        drive(1'b0, 1'b1);
        #1;
        chk("async", 32'h0, {30'h0, out_a, out_b});
        repeat (6) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        // A high active, B low pin on falling polarity, both events sticky
        chk("status", 32'h33, q);
        drive(1'b0, 1'b0);
        #1;
        chk("async off", 32'h3, {30'h0, out_a, out_b});
        // Write one to clear both events; mode 0 sets none again
        apb(1'b1, STATUS_OFS, 32'h30);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status clear", 32'h2, q);
        report_and_stop();
    end
endmodule
bind rpp_input_ctl rpp_input_ctl_props u_rpp_input_ctl_props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_condition_pin_a(external_condition_pin_a),
    .external_condition_pin_b(external_condition_pin_b),
    .comparator_a(comparator_a), .comparator_b(comparator_b),
    .one_ramp_mode(one_ramp_mode), .wave_phase(wave_phase),
    .gen_out_a(gen_out_a), .gen_out_b(gen_out_b), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .sub_cycle_a_end(sub_cycle_a_end),
    .sub_cycle_b_end(sub_cycle_b_end), .counter_clear(counter_clear));
`default_nettype wire
